//--- common/srer_pkg.sv
// shared constants for the status reporting event registers
package srer_pkg;
   // standard event flag bit positions
   localparam int EV_OPC_BIT   = 0;
   localparam int EV_QERR_BIT  = 2;
   localparam int EV_DERR_BIT  = 3;
   localparam int EV_EXE_BIT   = 4;
   localparam int EV_CMD_BIT   = 5;
   localparam int EV_URQ_BIT   = 6;
   localparam int EV_PON_BIT   = 7;
   localparam logic [7:0] EV_USED_MASK = 8'hFD;
   // status byte bit positions
   localparam int SB_ERRQ_BIT  = 2;
   localparam int SB_QUES_BIT  = 3;
   localparam int SB_MAV_BIT   = 4;
   localparam int SB_ESB_BIT   = 5;
   localparam int SB_MSS_BIT   = 6;
   localparam int SB_OPER_BIT  = 7;
   // operation status bit positions
   localparam int OP_CAL_BIT   = 0;
   localparam int OP_SWP_BIT   = 3;
   localparam logic [15:0] OP_USED_MASK = 16'h0009;
   localparam logic [15:0] QU_USED_MASK = 16'h0000;
   // reset values
   localparam logic [7:0]  EV_RESET   = 8'h00;
   localparam logic [7:0]  MASK8_RST  = 8'h00;
   localparam logic [15:0] MASK16_RST = 16'h0000;
   localparam logic [15:0] PTR_RST    = 16'hFFFF;
   // register select codes on the status command port
   typedef enum logic [3:0] {
      SEL_EVENT_FLAGS, SEL_EVENT_ENABLE, SEL_STATUS_BYTE, SEL_SRQ_ENABLE,
      SEL_QUES_COND, SEL_QUES_EVENT, SEL_QUES_ENABLE, SEL_QUES_PTR, SEL_QUES_NTR,
      SEL_OPER_COND, SEL_OPER_EVENT, SEL_OPER_ENABLE, SEL_OPER_PTR, SEL_OPER_NTR,
      SEL_NONE
   } srer_sel_t;
endpackage

//--- src/srer_scpi_reg.sv
// SCPI style condition/transition/event/enable register group
`timescale 1ns/1ps
`default_nettype none
module srer_scpi_reg
   import srer_pkg::*;
#(
   parameter int          W        = 16,
   parameter logic [15:0] USED     = 16'h0000
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] cond,
   input  wire logic         eventRead,
   input  wire logic         enWr,
   input  wire logic         ptrWr,
   input  wire logic         ntrWr,
   input  wire logic [W-1:0] wrData,
   output var  logic [W-1:0] condOut,
   output var  logic [W-1:0] eventOut,
   output var  logic [W-1:0] enableOut,
   output var  logic [W-1:0] ptrOut,
   output var  logic [W-1:0] ntrOut,
   output var  logic         sumBit
);
   // the used-bit mask is 16 wide, so wider groups cannot be served
   if (W < 1 || W > 16) begin : gBadWidth
      $error("srer_scpi_reg: W must be 1..16");
   end
   logic [W-1:0] usedBits;
   logic [W-1:0] prevCond;
   logic [W-1:0] setBits;
   assign usedBits = USED[W-1:0];
   assign condOut  = cond & usedBits;
   // transition filters decide which edges latch
   assign setBits = ((condOut & ~prevCond & ptrOut) |
                     (~condOut & prevCond & ntrOut)) & usedBits; // RULE_20
   assign sumBit = |(eventOut & enableOut); // RULE_22

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) prevCond <= '0;
      else if (clkEn) prevCond <= condOut;
   end
   // read clears, but a same-cycle set survives
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) eventOut <= '0;
      else if (clkEn) eventOut <= (eventRead ? '0 : eventOut) | setBits; // RULE_19
   end
   // masks only change on writes; unused bits stay zero
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         enableOut <= MASK16_RST[W-1:0];
         ptrOut    <= PTR_RST[W-1:0] & USED[W-1:0];
         ntrOut    <= MASK16_RST[W-1:0];
      end else if (clkEn) begin
         if (enWr)  enableOut <= wrData & usedBits; // RULE_23
         if (ptrWr) ptrOut    <= wrData & usedBits;
         if (ntrWr) ntrOut    <= wrData & usedBits;
      end
   end
endmodule
`default_nettype wire

//--- src/srer_status_regs.sv
// status reporting: event flags, status byte, service request, SCPI groups
//
// Operation
// (RULE_01) enabled new event flag sets summary bit
// (RULE_02) operation complete flag after prior commands finish
// (RULE_03) query error flag on bad reads
// (RULE_04) device error flag on device fault
// (RULE_05) execution error flag on failed command
// (RULE_06) command error flag on malformed command
// (RULE_07) user request flag on local switch
// (RULE_08) power on flag; bit 1 unused
// (RULE_09) questionable register entirely unused
// (RULE_10) condition is live, event is latched
// (RULE_11) operation bit 0 during calibration
// (RULE_12) operation bit 3 during sweep
// (RULE_13) service request from enabled bits 2,4,5
// (RULE_14) event read, enable write and readback
// (RULE_15) serial poll returns status byte
// (RULE_16) separate condition and event reads
// (RULE_17) controller should enable every bit
// (RULE_18) enable 1 and 32 gives request on completion
// (RULE_19) event read clears, masks unaffected
// (RULE_20) transition filters gate event setting
// (RULE_21) summary bit 6 ignores its mask bit
// (RULE_22) operation and questionable summary bits
// (RULE_23) unused bits read zero, ignore writes; event enable bit 1 and request enable bits 0-1 still read back as written
// (RULE_24) single-cycle strobes drive event flags
`timescale 1ns/1ps
`default_nettype none
module srer_status_regs
   import srer_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              clkEn,
   input  wire logic              opcCmd,
   input  wire logic              cmdsPending,
   input  wire logic              queryErr,
   input  wire logic              deviceErr,
   input  wire logic              execErr,
   input  wire logic              cmdErr,
   input  wire logic              localSwitch,
   input  wire logic              powerUp,
   input  wire logic              errQueueNotEmpty,
   input  wire logic              msgAvailable,
   input  wire logic              calibratingPin,
   input  wire logic              sweepingPin,
   input  wire logic              regRd,
   input  wire logic              regWr,
   input  wire srer_pkg::srer_sel_t regSel,
   input  wire logic [15:0]       regWrData,
   input  wire logic              serialPoll,
   output logic [15:0]            regRdData,
   output logic                   regRdValid,
   output logic [7:0]             pollByte,
   output logic                   pollValid,
   output logic                   srqOut
);
   import srer_pkg::*;

   logic [7:0]  evFlags_reg;
   logic [7:0]  evFlags_next;
   logic [7:0]  evEnable_reg;
   logic [7:0]  srqEnable_reg;
   logic [7:0]  evSet;
   logic        opcArmed_reg;
   logic        opcDone;
   logic [1:0]  opSync;
   logic [15:0] opCond;
   logic [15:0] opCondOut, opEvent, opEnable, opPtr, opNtr;
   logic [15:0] quCondOut, quEvent, quEnable, quPtr, quNtr;
   logic        opSum, quSum;
   logic [7:0]  statusByte;
   logic        srqNow;
   logic [7:0]  srqCauseMask;
   logic [7:0]  mssMask;
   logic [15:0] rdMux;

   // calibration and sweep arrive from analogue control, so synchronise
   srer_sync2 #(.W(2)) uSync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .din     ({sweepingPin, calibratingPin}),
      .dout    (opSync)
   );

   // live operation conditions
   always_comb begin
      opCond             = 16'h0000;
      opCond[OP_CAL_BIT] = opSync[0]; // RULE_11
      opCond[OP_SWP_BIT] = opSync[1]; // RULE_12
   end

   // operation group
   srer_scpi_reg #(.W(16), .USED(OP_USED_MASK)) uOper (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clkEn     (clkEn),
      .cond      (opCond), // RULE_10
      .eventRead (regRd && regSel == SEL_OPER_EVENT),
      .enWr      (regWr && regSel == SEL_OPER_ENABLE),
      .ptrWr     (regWr && regSel == SEL_OPER_PTR),
      .ntrWr     (regWr && regSel == SEL_OPER_NTR),
      .wrData    (regWrData),
      .condOut   (opCondOut),
      .eventOut  (opEvent),
      .enableOut (opEnable),
      .ptrOut    (opPtr),
      .ntrOut    (opNtr),
      .sumBit    (opSum)
   );

   // questionable group: no bit is used, so it reads all zero
   srer_scpi_reg #(.W(16), .USED(QU_USED_MASK)) uQues (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .clkEn     (clkEn),
      .cond      (16'h0000), // RULE_09
      .eventRead (regRd && regSel == SEL_QUES_EVENT),
      .enWr      (regWr && regSel == SEL_QUES_ENABLE),
      .ptrWr     (regWr && regSel == SEL_QUES_PTR),
      .ntrWr     (regWr && regSel == SEL_QUES_NTR),
      .wrData    (regWrData),
      .condOut   (quCondOut),
      .eventOut  (quEvent),
      .enableOut (quEnable),
      .ptrOut    (quPtr),
      .ntrOut    (quNtr),
      .sumBit    (quSum)
   );

   // operation complete waits until earlier commands drain
   assign opcDone = (opcCmd || opcArmed_reg) && !cmdsPending; // RULE_02
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) opcArmed_reg <= 1'b0;
      else if (clkEn) opcArmed_reg <= (opcCmd || opcArmed_reg) && cmdsPending;
   end

   // event strobes into flag positions
   always_comb begin
      evSet              = 8'h00;
      evSet[EV_OPC_BIT]  = opcDone;     // RULE_24
      evSet[EV_QERR_BIT] = queryErr;    // RULE_03
      evSet[EV_DERR_BIT] = deviceErr;   // RULE_04
      evSet[EV_EXE_BIT]  = execErr;     // RULE_05
      evSet[EV_CMD_BIT]  = cmdErr;      // RULE_06
      evSet[EV_URQ_BIT]  = localSwitch; // RULE_07
      evSet[EV_PON_BIT]  = powerUp;     // RULE_08
   end

   // read clears, a same-cycle set wins
   always_comb begin
      evFlags_next = evFlags_reg;
      if (regRd && regSel == SEL_EVENT_FLAGS) evFlags_next = 8'h00; // RULE_19
      evFlags_next = (evFlags_next | evSet) & EV_USED_MASK; // RULE_23
   end
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) evFlags_reg <= EV_RESET;
      else if (clkEn) evFlags_reg <= evFlags_next;
   end

   // enable masks written by the controller
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         evEnable_reg  <= MASK8_RST;
         srqEnable_reg <= MASK8_RST;
      end else if (clkEn && regWr) begin
         if (regSel == SEL_EVENT_ENABLE) evEnable_reg <= regWrData[7:0]; // RULE_14
         else if (regSel == SEL_SRQ_ENABLE) srqEnable_reg <= regWrData[7:0]; // RULE_18
      end
   end

   // request causes and summary mask built from bit positions, so a moved
   // bit cannot leave a stale literal behind
   always_comb begin
      srqCauseMask              = 8'h00;
      srqCauseMask[SB_ERRQ_BIT] = 1'b1; // RULE_13
      srqCauseMask[SB_MAV_BIT]  = 1'b1;
      srqCauseMask[SB_ESB_BIT]  = 1'b1;
      mssMask                   = 8'hFF;
      mssMask[SB_MSS_BIT]       = 1'b0; // RULE_21
   end

   // status byte; mss uses every other bit with its mask, its own mask ignored
   always_comb begin
      statusByte              = 8'h00;
      statusByte[SB_ERRQ_BIT] = errQueueNotEmpty;
      statusByte[SB_QUES_BIT] = quSum;                       // RULE_22
      statusByte[SB_MAV_BIT]  = msgAvailable;
      statusByte[SB_ESB_BIT]  = |(evFlags_reg & evEnable_reg); // RULE_01
      statusByte[SB_OPER_BIT] = opSum;                       // RULE_22
      statusByte[SB_MSS_BIT]  = |(statusByte & srqEnable_reg & mssMask); // RULE_21
   end
   // request limited to error queue, message and event summary
   assign srqNow = |(statusByte & srqEnable_reg & srqCauseMask); // RULE_13

   // read multiplexer; if-chain decode
   always_comb begin
      rdMux = 16'h0000;
      if (regSel == SEL_EVENT_FLAGS) rdMux = {8'h00, evFlags_reg}; // RULE_14
      else if (regSel == SEL_EVENT_ENABLE) rdMux = {8'h00, evEnable_reg};
      else if (regSel == SEL_STATUS_BYTE) rdMux = {8'h00, statusByte};
      else if (regSel == SEL_SRQ_ENABLE) rdMux = {8'h00, srqEnable_reg & mssMask};
      else if (regSel == SEL_QUES_COND) rdMux = quCondOut; // RULE_16
      else if (regSel == SEL_QUES_EVENT) rdMux = quEvent;
      else if (regSel == SEL_QUES_ENABLE) rdMux = quEnable;
      else if (regSel == SEL_QUES_PTR) rdMux = quPtr;
      else if (regSel == SEL_QUES_NTR) rdMux = quNtr;
      else if (regSel == SEL_OPER_COND) rdMux = opCondOut; // RULE_16
      else if (regSel == SEL_OPER_EVENT) rdMux = opEvent;
      else if (regSel == SEL_OPER_ENABLE) rdMux = opEnable;
      else if (regSel == SEL_OPER_PTR) rdMux = opPtr;
      else if (regSel == SEL_OPER_NTR) rdMux = opNtr;
   end

   // registered answers; read data captured before the clear takes effect
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData  <= 16'h0000;
         regRdValid <= 1'b0;
      end else if (clkEn) begin
         regRdValid <= regRd;
         if (regRd) regRdData <= rdMux;
      end
   end
   // serial poll gives the same byte as the status byte query
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pollByte  <= 8'h00;
         pollValid <= 1'b0;
      end else if (clkEn) begin
         pollValid <= serialPoll;
         if (serialPoll) pollByte <= statusByte; // RULE_15
      end
   end
   // service request line, registered
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) srqOut <= 1'b0;
      else if (clkEn) srqOut <= srqNow; // RULE_13
   end

   // checks
   // flag pipeline steps: strobe with both masks set, then a running cycle
   sequence seqOpcStrobe;
      clkEn && evSet[EV_OPC_BIT] && evEnable_reg[EV_OPC_BIT] && srqEnable_reg[SB_ESB_BIT]
      && !(regWr && regSel inside {SEL_EVENT_ENABLE, SEL_SRQ_ENABLE});
   endsequence
   sequence seqRunCycle;
      clkEn;
   endsequence
   AST_ESB_FOLLOWS_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // RULE_18
      seqOpcStrobe ##1 seqRunCycle |=> srqOut)
      else $error("enabled flag did not raise request");

   // completion steps: request seen or armed, with the queue drained in the same cycle
   sequence seqOpcWanted;
      clkEn && (opcCmd || opcArmed_reg);
   endsequence
   AST_OPC_WAITS: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
      clkEn && cmdsPending && !evFlags_reg[EV_OPC_BIT] |=> !evFlags_reg[EV_OPC_BIT])
      else $error("opc set while busy");
   AST_OPC_FIRES: assert property (@(posedge sys_clk) disable iff (rst) // RULE_02
      seqOpcWanted ##0 !cmdsPending |=> evFlags_reg[EV_OPC_BIT])
      else $error("opc not set after commands drained");

   // strobe-to-flag and read-clear behaviour
   AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
      clkEn && cmdErr |=> evFlags_reg[EV_CMD_BIT]) else $error("command error lost");
   AST_READ_CLEARS: assert property (@(posedge sys_clk) disable iff (rst) // RULE_19
      clkEn && regRd && regSel == SEL_EVENT_FLAGS && evSet == 8'h00
      |=> evFlags_reg == 8'h00) else $error("event flags not cleared");

   // unused parts stay quiet
   AST_BIT1_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // RULE_23
      !evFlags_reg[1]) else $error("unused flag bit set");
   AST_QUES_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // RULE_09
      quEvent == 16'h0000 && quCondOut == 16'h0000) else $error("ques nonzero");

   // answers, summaries and the request line
   AST_POLL_MATCH: assert property (@(posedge sys_clk) disable iff (rst) // RULE_15
      clkEn && serialPoll |=> pollValid && pollByte == $past(statusByte))
      else $error("poll byte mismatch");
   AST_SRQ_BIT6_IGNORED: assert property (@(posedge sys_clk) disable iff (rst) // RULE_13
      clkEn && !(|(statusByte & srqEnable_reg & srqCauseMask)) |=> !srqOut)
      else $error("request without enabled cause");
   AST_OPER_SUM: assert property (@(posedge sys_clk) disable iff (rst) // RULE_22
      statusByte[SB_OPER_BIT] == |(opEvent & opEnable)) else $error("oper sum");
   AST_RD_ANSWER: assert property (@(posedge sys_clk) disable iff (rst) // RULE_14
      clkEn && regRd |=> regRdValid)
      else $error("read not answered");

   // register writes and readback
   AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (rst) // RULE_14
      clkEn && regWr && regSel == SEL_EVENT_ENABLE
      |=> {8'h00, evEnable_reg} == ($past(regWrData) & 16'h00FF))
      else $error("event enable write lost");
   AST_SRE_BIT6_READ: assert property (@(posedge sys_clk) disable iff (rst) // RULE_21
      clkEn && regRd && regSel == SEL_SRQ_ENABLE |=> !regRdData[SB_MSS_BIT])
      else $error("request mask bit 6 read as one");

   // clock enable low holds every register, strobes included
   AST_CLKEN_FREEZE: assert property (@(posedge sys_clk) disable iff (rst) // RULE_24
      !clkEn |=> $stable(evFlags_reg) && $stable(srqOut) && $stable(regRdValid))
      else $error("state moved while clock enable low");
endmodule
`default_nettype wire

//--- src/srer_sync2.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module srer_sync2 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   input  wire logic         clkEn,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   logic [W-1:0] meta;
   // first stage feeds only the second
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta <= '0;
         dout <= '0;
      end else if (clkEn) begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule
`default_nettype wire

//--- verification/srer_ctl_model.sv
// controller-side model: register commands and serial polls
`timescale 1ns/1ps
`default_nettype none
module srer_ctl_model (
   input  wire logic                sys_clk,
   input  wire logic [15:0]         regRdData,
   input  wire logic                regRdValid,
   input  wire logic [7:0]          pollByte,
   input  wire logic                pollValid,
   output var  logic                regRd,
   output var  logic                regWr,
   output var  srer_pkg::srer_sel_t regSel,
   output var  logic [15:0]         regWrData,
   output var  logic                serialPoll
);
   import srer_pkg::*;
   // idle bus at time zero
   initial begin
      regRd = 1'b0;
      regWr = 1'b0;
      regSel = SEL_NONE;
      regWrData = 16'h0000;
      serialPoll = 1'b0;
   end
   // callers enter just after an edge; request holds until the taking edge
   task automatic wr(input srer_sel_t s, input logic [15:0] v);
      regSel = s;
      regWrData = v;
      regWr = 1'b1;
      @(posedge sys_clk) #1;
      regWr = 1'b0;
      regSel = SEL_NONE;
      regWrData = ~v; // released data must not look valid
      // idle edge so back-to-back calls never retoggle a strobe
      @(posedge sys_clk) #1;
   endtask
   task automatic rd(input srer_sel_t s, output logic [15:0] v, output logic ok);
      regSel = s;
      regRd = 1'b1;
      @(posedge sys_clk) #1;
      regRd = 1'b0;
      regSel = SEL_NONE;
      ok = regRdValid;
      v = regRdData;
      @(posedge sys_clk) #1;
   endtask
   // poll rides an interface message, not a command
   task automatic poll(output logic [7:0] b, output logic ok);
      serialPoll = 1'b1;
      @(posedge sys_clk) #1;
      serialPoll = 1'b0;
      ok = pollValid;
      b = pollByte;
      @(posedge sys_clk) #1;
   endtask
   // recommended setup: every event enable and request enable bit on
   task automatic enableAll();
      wr(SEL_EVENT_ENABLE, 16'h00FF);
      wr(SEL_SRQ_ENABLE, 16'h00FF);
   endtask
endmodule
`default_nettype wire

//--- verification/test_srer_status_regs.sv
// self-checking bench for the status reporting event registers
`timescale 1ns/1ps
`default_nettype none
module test_srer_status_regs;
   import srer_pkg::*;
   logic                sys_clk, rst, clkEn, cmdsPending, errQueueNotEmpty, msgAvailable;
   logic                calibratingPin, sweepingPin, regRd, regWr, serialPoll;
   logic                regRdValid, pollValid, srqOut, ok;
   logic [7:0]          strb, pollByte, pb;
   logic [15:0]         regWrData, regRdData, d;
   srer_sel_t           regSel;
   logic [31:0]         seed;
   int                  n_mismatch, tests_run, i;

   srer_status_regs dut (.sys_clk, .rst, .clkEn, .opcCmd(strb[0]), .cmdsPending,
      .queryErr(strb[2]), .deviceErr(strb[3]), .execErr(strb[4]), .cmdErr(strb[5]),
      .localSwitch(strb[6]), .powerUp(strb[7]), .errQueueNotEmpty, .msgAvailable,
      .calibratingPin, .sweepingPin, .regRd, .regWr, .regSel, .regWrData, .serialPoll,
      .regRdData, .regRdValid, .pollByte, .pollValid, .srqOut);
   srer_ctl_model ctl (.sys_clk, .regRdData, .regRdValid, .pollByte, .pollValid,
      .regRd, .regWr, .regSel, .regWrData, .serialPoll);

   // 8 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   // bit 1 has no source, so it never shows
   function automatic logic [15:0] expFlags(input logic [7:0] r);
      return {8'h00, r & EV_USED_MASK};
   endfunction

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic rdChk(input srer_sel_t s, input logic [15:0] exp, input string nm);
      ctl.rd(s, d, ok);
      chk({nm, " valid"}, {15'h0000, ok}, 16'h0001);
      chk(nm, d, exp);
   endtask
   task automatic pollChk(input logic [7:0] exp);
      ctl.poll(pb, ok);
      chk("poll valid", {15'h0000, ok}, 16'h0001);
      chk("poll byte", {8'h00, pb}, {8'h00, exp});
   endtask
   task automatic pulse(input logic [7:0] p);
      strb = p;
      @(posedge sys_clk) #1;
      strb = 8'h00;
   endtask
   // bounded wait; a hang ends the run
   task automatic waitSrq(input logic v);
      for (int k = 0; k < 8 && srqOut !== v; k++) @(posedge sys_clk) #1;
      chk("srqOut", {15'h0000, srqOut}, {15'h0000, v});
      if (srqOut !== v) stop_test();
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end

   initial begin
      rst = 1'b1;
      clkEn = 1'b1;
      strb = 8'h00;
      cmdsPending = 1'b0;
      errQueueNotEmpty = 1'b0;
      msgAvailable = 1'b0;
      calibratingPin = 1'b0;
      sweepingPin = 1'b0;
      n_mismatch = 0;
      tests_run = 0;
      seed = 32'h0000D2B2;
      repeat (12) @(posedge sys_clk);
      #1 rst = 1'b0;
      // reset state
      rdChk(SEL_EVENT_FLAGS, 16'h0000, "flags");
      rdChk(SEL_OPER_PTR, 16'h0009, "oper ptr");
      rdChk(SEL_QUES_COND, 16'h0000, "ques cond");
      rdChk(SEL_NONE, 16'h0000, "no select");
      // every strobe at once, then random mixes; second read sees cleared flags
      pulse(8'hFF);
      rdChk(SEL_EVENT_FLAGS, 16'h00FD, "all flags");
      for (i = 0; i < 20; i++) begin
         seed = xs(seed);
         pulse(seed[7:0]);
         rdChk(SEL_EVENT_FLAGS, expFlags(seed[7:0]), "flags");
         rdChk(SEL_EVENT_FLAGS, 16'h0000, "flags clr");
      end
      // completion waits for earlier commands, then requests service
      ctl.wr(SEL_EVENT_ENABLE, 16'h0001);
      ctl.wr(SEL_SRQ_ENABLE, 16'h0020);
      cmdsPending = 1'b1;
      pulse(8'h01);
      repeat (4) @(posedge sys_clk) #1;
      chk("srq early", {15'h0000, srqOut}, 16'h0000);
      cmdsPending = 1'b0;
      waitSrq(1'b1);
      pollChk(8'h60);
      rdChk(SEL_STATUS_BYTE, 16'h0060, "stb query");
      rdChk(SEL_EVENT_FLAGS, 16'h0001, "opc flag");
      waitSrq(1'b0);
      // masked flag gives no summary
      ctl.wr(SEL_EVENT_ENABLE, 16'h0000);
      pulse(8'h20);
      repeat (2) @(posedge sys_clk) #1;
      pollChk(8'h00);
      rdChk(SEL_EVENT_FLAGS, 16'h0020, "cmd flag");
      // queue and message bits with full enables
      ctl.enableAll();
      rdChk(SEL_SRQ_ENABLE, 16'h00BF, "sre");
      errQueueNotEmpty = 1'b1;
      waitSrq(1'b1);
      pollChk(8'h44);
      errQueueNotEmpty = 1'b0;
      msgAvailable = 1'b1;
      repeat (2) @(posedge sys_clk) #1;
      pollChk(8'h50);
      msgAvailable = 1'b0;
      waitSrq(1'b0);
      // operation group: filters, live condition, latched event
      ctl.wr(SEL_OPER_ENABLE, 16'hFFFF);
      rdChk(SEL_OPER_ENABLE, 16'h0009, "oper en");
      ctl.wr(SEL_OPER_NTR, 16'h0008);
      calibratingPin = 1'b1;
      repeat (4) @(posedge sys_clk) #1;
      rdChk(SEL_OPER_COND, 16'h0001, "oper cond");
      pollChk(8'hC0);
      chk("srq oper", {15'h0000, srqOut}, 16'h0000);
      rdChk(SEL_OPER_EVENT, 16'h0001, "oper ev");
      calibratingPin = 1'b0;
      repeat (4) @(posedge sys_clk) #1;
      rdChk(SEL_OPER_EVENT, 16'h0000, "oper ev fall");
      sweepingPin = 1'b1;
      repeat (4) @(posedge sys_clk) #1;
      sweepingPin = 1'b0;
      repeat (4) @(posedge sys_clk) #1;
      rdChk(SEL_OPER_EVENT, 16'h0008, "sweep ev");
      rdChk(SEL_OPER_NTR, 16'h0008, "oper ntr");
      ctl.wr(SEL_OPER_COND, 16'hFFFF);
      rdChk(SEL_OPER_COND, 16'h0000, "cond ro");
      ctl.wr(SEL_QUES_ENABLE, 16'hFFFF);
      rdChk(SEL_QUES_ENABLE, 16'h0000, "ques en");
      rdChk(SEL_QUES_EVENT, 16'h0000, "ques ev");
      rdChk(SEL_QUES_PTR, 16'h0000, "ques ptr");
      // clock enable low: strobes and reads are not taken
      clkEn = 1'b0;
      pulse(8'h20);
      ctl.rd(SEL_EVENT_FLAGS, d, ok);
      chk("frozen valid", {15'h0000, ok}, 16'h0000);
      clkEn = 1'b1;
      rdChk(SEL_EVENT_FLAGS, 16'h0000, "frozen flags");
      stop_test();
   end
endmodule
`default_nettype wire
